/* File: common/css_pkg.sv */
/*
 * constants, field layouts and state codes for the clocked synchronous
 * 8-bit serial block.
 * assumes a 25 MHz system clock and an Avalon-MM slave port with
 * byte addresses, one 32-bit word per register.
 */
package css_pkg;

	// register byte addresses
	localparam logic [3:0] ADDR_DATA = 4'h0;
	localparam logic [3:0] ADDR_CTRL = 4'h4;
	localparam logic [3:0] ADDR_STAT = 4'h8;

	// status bit positions
	localparam int unsigned STAT_TX_FULL = 0;
	localparam int unsigned STAT_RX_AVAIL = 1;
	localparam int unsigned STAT_SHIFTING = 2;
	localparam int unsigned STAT_ACTIVE = 3;

	// transfer mode field codes
	typedef enum logic [1:0]
	{
		MODE_NONE = 2'b00,
		MODE_TX = 2'b01,
		MODE_RX = 2'b10,
		MODE_TRX = 2'b11
	} css_mode_t;

	// control word layout, bit 7 down to bit 0
	typedef struct packed
	{
		logic [2:0] clock_source_field;
		logic edge_sel;
		css_mode_t transfer_mode_field;
		logic transfer_inhibit_bit;
		logic transfer_start_bit;
	} css_ctrl_t;

	// inhibit set, everything else clear
	localparam logic [7:0] CTRL_RESET = 8'h02;
	localparam logic [2:0] CLK_EXTERNAL = 3'h7;

	// internal clock half period is this base shifted by the select
	localparam logic [7:0] DIV_BASE_CYCLES = 8'h02;

	// output level between frames
	localparam logic SO_IDLE = 1'b1;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_LOAD = 2'b01,
		ST_SHIFT = 2'b10,
		ST_WAIT = 2'b11
	} css_state_t;

endpackage

/* File: rtl/css_top.sv */
/*
 * clocked synchronous 8-bit serial transfer block: one shared data
 * buffer, one shift register, internal or external serial clock,
 * Avalon-MM register slave.
 * assumes sck_i and si come from pins (synchronised here) and that
 * the board resolves sck from sck_o and sck_oe_n.
 */
// The register addresses and register access over Avalon-MM were chosen for this implementation.
// Function
// - leading-edge shift drives data on the leading clock edge and samples on the trailing; trailing-edge shift does the reverse
// - leading-edge shift works on the falling edge of the clock pin
// - trailing-edge shift works on the rising edge of the clock pin
// - two-bit mode field picks transmit, receive or both
// - start loads buffer into shift register, sent out lsb first
// - loading a transmit byte empties the buffer; in transmit-only mode it also requests new data by interrupt
// - internal clock stops after a byte until new data is written
// - serial output holds last bit until next external clock falling edge; with internal clock, until the next load
// - clearing start finishes pending data, then clears active flag
// - inhibit stops transmission at once and clears active flag
// - external clock without start cleared: one dummy byte, then end
// - receive shifts lsb first, full byte goes to buffer, interrupt
// - internal clock receive waits until the byte has been read
// - external receive: unread buffer makes following bytes discarded
// - clearing start in receive keeps whole bytes only, then ends
// - inhibit stops reception at once, partial byte thrown away
// - changing the transfer mode discards the buffer contents
// - combined mode puts each received byte in buffer, interrupt
// - internal clock combined mode waits for both read and write
// - clock source all ones selects the external clock pin
// - internal clock: seven selectable rates, driven on clock pin
`timescale 1ns/10ps
module css_top
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe_n,
	input wire logic si,
	output logic so,
	output logic serial_interrupt_request
);

	css_pkg::css_ctrl_t ctrl_q;
	css_pkg::css_ctrl_t ctrl_wr;
	css_pkg::css_state_t state_q;
	logic ack_q;
	logic req;
	logic wr_fire;
	logic rd_data_fire;
	logic wr_ctrl;
	logic wr_data;
	logic start_go;
	logic mode_chg;
	logic [31:0] readdata_q;
	logic sck_s1_q;
	logic sck_s2_q;
	logic sck_s3_q;
	logic si_s1_q;
	logic si_s2_q;
	logic sck_int_q;
	logic [7:0] div_cnt_q;
	logic [7:0] half_cycles;
	logic ext_clk;
	logic tick;
	logic fall_edge;
	logic rise_edge;
	logic sample_edge;
	logic drive_edge;
	logic [7:0] buf_q;
	logic [7:0] sreg_q;
	logic [7:0] rx_byte;
	logic [2:0] bit_cnt_q;
	logic tx_full_q;
	logic rx_avail_q;
	logic active_q;
	logic end_after_q;
	logic so_q;
	logic irq_q;
	logic has_tx;
	logic has_rx;
	logic next_ready;

	// bus slave: one wait cycle, then the answer
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_q;
	assign wr_fire = avs_write & ack_q;
	assign rd_data_fire = avs_read & ack_q &
		(avs_address == css_pkg::ADDR_DATA);
	assign wr_ctrl = wr_fire & (avs_address == css_pkg::ADDR_CTRL);
	assign wr_data = wr_fire & (avs_address == css_pkg::ADDR_DATA);
	assign ctrl_wr = css_pkg::css_ctrl_t'(avs_writedata[7:0]);
	assign start_go = wr_ctrl & ctrl_wr.transfer_start_bit &
		~ctrl_q.transfer_start_bit & ~ctrl_wr.transfer_inhibit_bit;
	assign mode_chg = wr_ctrl &
		(ctrl_wr.transfer_mode_field != ctrl_q.transfer_mode_field);
	assign avs_readdata = readdata_q;

	// acknowledge toggles once per request
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			ack_q <= 1'b0;
		else
			ack_q <= req & ~ack_q;
	end

	// read data latched in the wait cycle, unmapped reads give zero
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			readdata_q <= 32'h0000_0000;
		else if (req & ~ack_q)
		begin
			readdata_q <= 32'h0000_0000;
			unique case (avs_address)
				css_pkg::ADDR_DATA: readdata_q[7:0] <= buf_q;
				css_pkg::ADDR_CTRL: readdata_q[7:0] <= ctrl_q;
				css_pkg::ADDR_STAT:
				begin
					readdata_q[css_pkg::STAT_TX_FULL] <= tx_full_q;
					readdata_q[css_pkg::STAT_RX_AVAIL] <= rx_avail_q;
					readdata_q[css_pkg::STAT_SHIFTING] <=
						(state_q == css_pkg::ST_SHIFT);
					readdata_q[css_pkg::STAT_ACTIVE] <= active_q;
				end
				default: readdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// control register, software owned
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			ctrl_q <= css_pkg::css_ctrl_t'(css_pkg::CTRL_RESET);
		else if (wr_ctrl)
			ctrl_q <= ctrl_wr;
	end

	// pin synchronisers; third clock stage only feeds edge detection
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sck_s1_q <= 1'b1;
			sck_s2_q <= 1'b1;
			sck_s3_q <= 1'b1;
			si_s1_q <= 1'b0;
			si_s2_q <= 1'b0;
		end
		else
		begin
			sck_s1_q <= sck_i;
			sck_s2_q <= sck_s1_q;
			sck_s3_q <= sck_s2_q;
			si_s1_q <= si;
			si_s2_q <= si_s1_q;
		end
	end

	// clock source and edge selection
	assign ext_clk = (ctrl_q.clock_source_field == css_pkg::CLK_EXTERNAL);
	assign half_cycles = css_pkg::DIV_BASE_CYCLES <<
		ctrl_q.clock_source_field;
	assign tick = ~ext_clk & (state_q == css_pkg::ST_SHIFT) &
		(div_cnt_q == half_cycles - 8'h01);
	assign fall_edge = ext_clk ? (sck_s3_q & ~sck_s2_q) : (tick & sck_int_q);
	assign rise_edge = ext_clk ? (~sck_s3_q & sck_s2_q) : (tick & ~sck_int_q);
	// leading shift drives on fall, trailing shift drives on rise
	assign drive_edge = ctrl_q.edge_sel ? rise_edge : fall_edge;
	assign sample_edge = ctrl_q.edge_sel ? fall_edge : rise_edge;

	// internal clock divider, runs only while shifting
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			div_cnt_q <= 8'h00;
			sck_int_q <= 1'b1;
		end
		else if (ext_clk || state_q != css_pkg::ST_SHIFT)
		begin
			// park high so an abort never leaves the pin low
			div_cnt_q <= 8'h00;
			sck_int_q <= 1'b1;
		end
		else if (tick)
		begin
			div_cnt_q <= 8'h00;
			sck_int_q <= ~sck_int_q;
		end
		else
			div_cnt_q <= div_cnt_q + 8'h01;
	end

	assign sck_o = sck_int_q;
	assign sck_oe_n = ext_clk;

	// mode decode and readiness for the next byte
	assign has_tx = ctrl_q.transfer_mode_field[0];
	assign has_rx = ctrl_q.transfer_mode_field[1];
	// si reaches the shifter two cycles late: the fastest internal rate
	// leaves no time for a far side that changes data on the leading edge
	assign rx_byte = {si_s2_q, sreg_q[7:1]};
	always_comb
	begin
		unique case (ctrl_q.transfer_mode_field)
			css_pkg::MODE_TX: next_ready = tx_full_q;
			css_pkg::MODE_RX: next_ready = ~rx_avail_q;
			css_pkg::MODE_TRX: next_ready = ~rx_avail_q & tx_full_q;
			css_pkg::MODE_NONE: next_ready = 1'b0;
		endcase
	end

	// transfer sequencer with buffer bookkeeping
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_q <= css_pkg::ST_IDLE;
			sreg_q <= 8'h00;
			bit_cnt_q <= 3'h0;
			so_q <= css_pkg::SO_IDLE;
			active_q <= 1'b0;
			end_after_q <= 1'b0;
			buf_q <= 8'h00;
			tx_full_q <= 1'b0;
			rx_avail_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			irq_q <= 1'b0;
			if (rd_data_fire)
				rx_avail_q <= 1'b0;
			unique case (state_q)
				css_pkg::ST_IDLE:
				begin
					// last bit stands until the next falling edge of an external clock
					if (fall_edge)
						so_q <= css_pkg::SO_IDLE;
					if (start_go && ctrl_wr.transfer_mode_field !=
						css_pkg::MODE_NONE)
					begin
						state_q <= css_pkg::ST_LOAD;
						active_q <= 1'b1;
						end_after_q <= 1'b0;
					end
				end
				css_pkg::ST_LOAD:
				begin
					bit_cnt_q <= 3'h0;
					state_q <= css_pkg::ST_SHIFT;
					if (has_tx)
					begin
						sreg_q <= buf_q;
						so_q <= buf_q[0];
						tx_full_q <= 1'b0;
						// no fresh byte: stale buffer goes out as dummy
						if (!tx_full_q)
							end_after_q <= 1'b1;
						if (!has_rx)
							irq_q <= 1'b1;
					end
					else
						sreg_q <= 8'h00;
				end
				css_pkg::ST_SHIFT:
				begin
					if (sample_edge)
					begin
						sreg_q <= rx_byte;
						bit_cnt_q <= bit_cnt_q + 3'h1;
						if (bit_cnt_q == 3'h7)
						begin
							// whole byte only reaches the buffer
							if (has_rx && (!rx_avail_q || rd_data_fire))
							begin
								buf_q <= rx_byte;
								rx_avail_q <= 1'b1;
								irq_q <= 1'b1;
							end // unread buffer: byte discarded
							if (!ctrl_q.transfer_start_bit || end_after_q)
							begin
								state_q <= css_pkg::ST_IDLE;
								active_q <= 1'b0;
							end
							else if (ext_clk)
								state_q <= css_pkg::ST_LOAD;
							else
								state_q <= css_pkg::ST_WAIT;
						end
					end
					else if (drive_edge && bit_cnt_q != 3'h0)
						so_q <= sreg_q[0];
				end
				css_pkg::ST_WAIT:
				begin
					// internal clock held until software services buffer
					if (!ctrl_q.transfer_start_bit)
					begin
						state_q <= css_pkg::ST_IDLE;
						active_q <= 1'b0;
					end
					else if (next_ready)
						state_q <= css_pkg::ST_LOAD;
				end
			endcase
			// inhibit aborts at once, partial byte dropped
			if (ctrl_q.transfer_inhibit_bit && state_q != css_pkg::ST_IDLE)
			begin
				state_q <= css_pkg::ST_IDLE;
				active_q <= 1'b0;
			end
			if (mode_chg)
			begin
				buf_q <= 8'h00;
				tx_full_q <= 1'b0;
				rx_avail_q <= 1'b0;
			end
			// software write last so it wins over a same-cycle load
			if (wr_data)
			begin
				buf_q <= avs_writedata[7:0];
				tx_full_q <= 1'b1;
			end
		end
	end

	assign so = so_q;
	assign serial_interrupt_request = irq_q;

endmodule

/* File: testbench/css_properties.sv */
/*
 * port checks for the serial block, bound onto css_top.
 * assumes the control shadow below follows every acked bus write.
 */
`timescale 1ns/10ps
module css_properties
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic sck_o,
	input wire logic sck_oe_n,
	input wire logic serial_interrupt_request
);
	logic [7:0] ctrl_q;
	logic req;
	logic rd_st;

	// request and status-read decode
	assign req = avs_read || avs_write;
	assign rd_st = avs_read && !avs_waitrequest && avs_address == 4'h8;

	// shadow of the control register
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			ctrl_q <= css_pkg::CTRL_RESET;
		else if (avs_write && !avs_waitrequest && avs_address == 4'h4)
			ctrl_q <= avs_writedata[7:0];
	end

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	one_wait_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("no answer after one wait");
	no_wait_a: assert property (!req |-> !avs_waitrequest)
		else $error("wait without request");
	upper_zero_a: assert property (
		avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
		else $error("upper read bits set");
	unmapped_a: assert property (
		avs_read && !avs_waitrequest && avs_address > 4'h8
		|-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	ctrl_back_a: assert property (
		avs_read && !avs_waitrequest && avs_address == 4'h4
		|-> avs_readdata[7:0] == ctrl_q)
		else $error("control readback wrong");
	ext_clock_a: assert property (
		sck_oe_n == (ctrl_q[7:5] == css_pkg::CLK_EXTERNAL))
		else $error("clock pin direction wrong");
	irq_pulse_a: assert property (
		serial_interrupt_request |=> !serial_interrupt_request)
		else $error("irq longer than one cycle");
	inhibit_idle_a: assert property (
		ctrl_q[1] && $past(ctrl_q[1], 3) && rd_st |-> !avs_readdata[3])
		else $error("active while inhibited");
	sck_low_a: assert property (
		$fell(sck_o) && !sck_oe_n && ctrl_q[7:5] == 3'h0 && !ctrl_q[1]
		|=> !sck_o ##1 sck_o)
		else $error("low phase not two cycles");
	sck_high_a: assert property ($rose(sck_o) |=> sck_o)
		else $error("high phase too short");
endmodule

bind css_top css_properties i_css_properties
(
	.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .sck_o(sck_o), .sck_oe_n(sck_oe_n),
	.serial_interrupt_request(serial_interrupt_request)
);

/* File: testbench/css_peer.sv */
/*
 * far-side serial peer: leading-edge timing, lsb first.
 * assumes the bench fills tx_q and empties rx_q between scenarios.
 */
`timescale 1ns/10ps
module css_peer
(
	input wire logic sck_o,
	input wire logic sck_oe_n,
	input wire logic so,
	output logic sck_i,
	output logic si
);
	logic ext_q = 1'b1;
	logic [7:0] sh;
	int cnt = 0;
	logic [7:0] tx_q[$];
	logic [7:0] rx_q[$];

	// wire level: device drives while its enable is low
	assign sck_i = sck_oe_n ? ext_q : sck_o;
	initial si = 1'b1;
	// new bit on the fall, inverse of last when nothing is queued
	always @(negedge sck_i)
		si = tx_q.size() > 0 ? tx_q[0][cnt] : ~si;
	// sample on the rise, a byte every eight
	always @(posedge sck_i)
	begin
		sh = {so, sh[7:1]};
		cnt = cnt + 1;
		if (cnt == 8)
		begin
			rx_q.push_back(sh);
			if (tx_q.size() > 0)
				void'(tx_q.pop_front());
			cnt = 0;
		end
	end
	// external clock pulses, 320 ns each, stands high between
	task pulses(input int n);
		#10;
		repeat (n)
		begin
			#160 ext_q = 1'b0;
			#160 ext_q = 1'b1;
		end
	endtask
endmodule

/* File: testbench/css_top_tb_top.sv */
/*
 * register-level bench for the serial block.
 * assumes css_peer on the link and the bound port checker.
 */
`timescale 1ns/10ps
module css_top_tb_top;
	localparam logic [3:0] a_dat = css_pkg::ADDR_DATA;
	localparam logic [3:0] a_ctl = css_pkg::ADDR_CTRL;
	localparam logic [3:0] a_st = css_pkg::ADDR_STAT;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, sck_i, sck_o, sck_oe_n, si, so, irq;
	logic [7:0] q;
	int errors = 0;
	int cmp_count = 0;
	int cyc = 0;

	css_top i_css_top
	(
		.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .sck_i(sck_i), .sck_o(sck_o),
		.sck_oe_n(sck_oe_n), .si(si), .so(so),
		.serial_interrupt_request(irq)
	);
	css_peer i_css_peer
	(
		.sck_o(sck_o), .sck_oe_n(sck_oe_n), .so(so), .sck_i(sck_i), .si(si)
	);

	// 25 MHz clock
	initial
	begin
		forever #20 clk = ~clk;
	end
	// hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			errors = errors + 1;
			results();
		end
	end

	task results();
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e)
		begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// one access, held until waitrequest is seen low
	task acc(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= ~w;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		acc(1'b1, a, d);
	endtask
	task rd(input logic [3:0] a);
		acc(1'b0, a, 8'h00);
	endtask
	task wirq();
		do @(posedge clk); while (irq !== 1'b1);
	endtask
	task wpeer(input int n);
		while (i_css_peer.rx_q.size() < n) @(posedge clk);
	endtask

	// scenarios in order
	initial
	begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		i_css_peer.cnt = 0;
		rd(a_ctl);
		chk(q, css_pkg::CTRL_RESET);
		rd(a_st);
		chk(q, 8'h00);
		rd(4'hc);
		// internal transmit, waits after a byte
		wr(a_ctl, 8'h06);
		wr(a_dat, 8'ha5);
		wr(a_ctl, 8'h05);
		wirq();
		rd(a_st);
		chk(q & 8'h09, 8'h08);
		wpeer(1);
		chk(i_css_peer.rx_q[0], 8'ha5);
		repeat (40) @(posedge clk);
		chk({7'h0, sck_o}, 8'h01);
		chk(8'(i_css_peer.rx_q.size()), 8'h01);
		wr(a_dat, 8'h3c);
		wirq();
		wr(a_ctl, 8'h04);
		wpeer(2);
		chk(i_css_peer.rx_q[1], 8'h3c);
		repeat (8) @(posedge clk);
		rd(a_st);
		chk(q & 8'h08, 8'h00);
		// internal receive at rate 1, waits until read
		wr(a_ctl, 8'h06);
		wr(a_ctl, 8'h2a);
		i_css_peer.tx_q = '{8'h5a, 8'hc3};
		wr(a_ctl, 8'h29);
		wirq();
		repeat (40) @(posedge clk);
		chk(8'(i_css_peer.tx_q.size()), 8'h01);
		rd(a_st);
		chk(q & 8'h0a, 8'h0a);
		rd(a_dat);
		chk(q, 8'h5a);
		wr(a_ctl, 8'h28);
		wirq();
		repeat (4) @(posedge clk);
		rd(a_st);
		chk(q & 8'h0a, 8'h02);
		rd(a_dat);
		chk(q, 8'hc3);
		// combined at rate 1, waits for read and write
		wr(a_ctl, 8'h2a);
		wr(a_ctl, 8'h2e);
		wr(a_dat, 8'h96);
		i_css_peer.rx_q.delete();
		i_css_peer.tx_q = '{8'h69, 8'h11};
		wr(a_ctl, 8'h2d);
		wirq();
		rd(a_dat);
		chk(q, 8'h69);
		repeat (40) @(posedge clk);
		chk(8'(i_css_peer.rx_q.size()), 8'h01);
		wr(a_dat, 8'h22);
		wr(a_ctl, 8'h2c);
		wirq();
		rd(a_dat);
		chk(q, 8'h11);
		chk(i_css_peer.rx_q[0], 8'h96);
		chk(i_css_peer.rx_q[1], 8'h22);
		// mode change empties the buffer
		wr(a_ctl, 8'h2e);
		wr(a_ctl, 8'h0a);
		rd(a_dat);
		chk(q, 8'h00);
		// external transmit: reload, then one dummy byte and end
		wr(a_ctl, 8'he6);
		@(posedge clk);
		chk({7'h0, sck_oe_n}, 8'h01);
		i_css_peer.rx_q.delete();
		wr(a_dat, 8'h4b);
		wr(a_ctl, 8'he5);
		wirq();
		wr(a_dat, 8'hd2);
		i_css_peer.pulses(8);
		i_css_peer.pulses(8);
		i_css_peer.pulses(8);
		repeat (8) @(posedge clk);
		rd(a_st);
		chk(q & 8'h08, 8'h00);
		chk(i_css_peer.rx_q[0], 8'h4b);
		chk(i_css_peer.rx_q[1], 8'hd2);
		chk(i_css_peer.rx_q[2], 8'hd2);
		// external receive, unread byte, then abort
		wr(a_ctl, 8'hea);
		i_css_peer.tx_q = '{8'h81, 8'h7e, 8'h00};
		wr(a_ctl, 8'he9);
		i_css_peer.pulses(8);
		repeat (8) @(posedge clk);
		i_css_peer.pulses(8);
		repeat (8) @(posedge clk);
		rd(a_dat);
		chk(q, 8'h81);
		i_css_peer.pulses(4);
		wr(a_ctl, 8'hea);
		rd(a_st);
		chk(q & 8'h08, 8'h00);
		results();
	end
endmodule
